// File: rtl/ecr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecr_map.svh"
module ecr_top #(
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// fold one byte into the running code: each set bit xors its
	// in-sector bit address into p and its inverse into np
	function automatic logic [23:0] ecr_fold(input logic [23:0] acc, input logic [8:0] a,
		input logic [7:0] d, input logic [11:0] m);
		logic [11:0] p;
		logic [11:0] np;
		logic [11:0] ba;
		p = acc[11:0];
		np = acc[23:12];
		for (int b = 0; b < 8; b++) begin
			ba = {a, 3'(b)};
			if (d[b]) begin
				p = p ^ ba;
				np = np ^ ~ba;
			end
		end
		return {np & m, p & m};
	endfunction : ecr_fold

	// page length in bytes for a page selection
	function automatic logic [12:0] ecr_page_len(input logic [1:0] sel);
		case (sel)
			2'h0: ecr_page_len = `ECR_PAGE_512;
			2'h1: ecr_page_len = `ECR_PAGE_2048;
			default: ecr_page_len = `ECR_PAGE_4096;
		endcase
	endfunction : ecr_page_len

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ecr_pkg::ecr_state_e state, next_state; // engine state
	ecr_pkg::ecr_cfg_s cfg, next_cfg; // latched configuration
	logic [12:0] pos, next_pos; // byte index in the page
	logic [23:0] acc, next_acc; // running {np, p} for the sector
	logic [23:0] res [16]; // result words, 24 live bits
	logic [23:0] next_res [16];
	logic [23:0] refc [16]; // stored codes loaded before a read
	logic [23:0] next_refc [16];
	logic [15:0] err_single, next_err_single; // one error found
	logic [15:0] err_multi, next_err_multi; // uncorrectable
	logic done, next_done; // page finished, sticky
	logic [31:0] next_rdata;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic fifo_take;

	// ----------------------------------------------------------------
	// input buffer
	// ----------------------------------------------------------------
	// the engine only drains while running, so a stream that runs
	// ahead of a start fills the fifo and is held off at byte_ready
	ecr_fifo #(
		.WIDTH(8),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.in_valid(byte_valid),
		.in_data(byte_data),
		.in_ready(byte_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(fifo_take)
	);
	assign fifo_take = (state == ecr_pkg::st_run);

	// ----------------------------------------------------------------
	// code engine and register file, next values
	// ----------------------------------------------------------------
	always_comb begin
		logic [11:0] m;
		logic [8:0] loc;
		logic [3:0] sec;
		logic last;
		logic [23:0] a2;
		logic [11:0] s;
		logic [11:0] n;
		logic hit_one;
		logic hit_many;
		logic [3:0] ridx;
		m = cfg.layout_256 ? `ECR_MASK_256 : `ECR_MASK_512;
		// sector split of the page byte index
		loc = cfg.layout_256 ? {1'b0, pos[7:0]} : pos[8:0];
		sec = cfg.layout_256 ? pos[11:8] : {1'b0, pos[11:9]};
		last = cfg.layout_256 ? (loc == `ECR_SECT_LAST_256) : (loc == `ECR_SECT_LAST_512);
		a2 = ecr_fold(acc, loc, fifo_data, m);
		s = (a2[11:0] ^ refc[sec][11:0]) & m;
		n = (a2[23:12] ^ refc[sec][23:12]) & m;
		hit_one = ((s ^ n) == m); // one flipped bit: syndromes complement
		hit_many = !hit_one && ((s | n) != 12'h000);
		ridx = reg_addr[5:2];
		next_state = state;
		next_cfg = cfg;
		next_pos = pos;
		next_acc = acc;
		next_res = res;
		next_refc = refc;
		next_err_single = err_single;
		next_err_multi = err_multi;
		next_done = done;
		// streaming: one byte per cycle while running
		if (state == ecr_pkg::st_run && fifo_valid) begin
			next_acc = a2;
			next_pos = pos + 13'h0001;
			if (last) begin
				next_acc = '0;
				if (cfg.op_read) begin
					// location fields hold the syndrome; valid only for one error
					next_res[sec] = {n ^ m, s};
					next_err_single[sec] = hit_one;
					next_err_multi[sec] = hit_many;
				end else begin
					next_res[sec] = a2;
				end
			end
			if (next_pos == ecr_page_len(cfg.page_sel)) begin
				next_state = ecr_pkg::st_idle;
				next_done = 1'b1;
			end
		end
		// software writes; result words have no write path at all
		if (reg_wr) begin
			if (reg_addr == `ECR_CTRL && state == ecr_pkg::st_idle) begin
				next_cfg.op_read = reg_wdata[`ECR_CTRL_OP_READ];
				next_cfg.layout_256 = reg_wdata[`ECR_CTRL_LAYOUT_256];
				next_cfg.page_sel = reg_wdata[`ECR_CTRL_PAGE_LSB +: 2];
				if (reg_wdata[`ECR_CTRL_START]) begin
					next_state = ecr_pkg::st_run;
					next_pos = '0;
					next_acc = '0;
					next_done = 1'b0;
					next_err_single = '0;
					next_err_multi = '0;
				end
			end else if (reg_addr[7:6] == 2'b10 && reg_addr[1:0] == 2'b00) begin
				next_refc[ridx] = reg_wdata[23:0];
			end
		end
		// read data: answer stands one cycle, zero otherwise
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			if (reg_addr[7:6] == 2'b00 && reg_addr[1:0] == 2'b00) begin
				// upper eight bits and, in 512 layout, the upper eight words read zero
				if (!(cfg.layout_256 == 1'b0 && ridx[3])) begin
					next_rdata = {8'h00, res[ridx]};
				end
			end else if (reg_addr[7:6] == 2'b10 && reg_addr[1:0] == 2'b00) begin
				next_rdata = {8'h00, refc[ridx]};
			end else if (reg_addr == `ECR_CTRL) begin
				next_rdata = {27'h0, cfg.page_sel, cfg.layout_256, cfg.op_read, 1'b0};
			end else if (reg_addr == `ECR_STAT) begin
				next_rdata = {30'h0, done, state == ecr_pkg::st_run};
			end else if (reg_addr == `ECR_ERR) begin
				next_rdata = {err_multi, err_single};
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// result and reference words are reset to zero along with the control state
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state <= ecr_pkg::st_idle;
			cfg <= ecr_pkg::ecr_cfg_s'(`ECR_CTRL_RESET);
			pos <= '0;
			acc <= '0;
			err_single <= '0;
			err_multi <= '0;
			done <= 1'b0;
			reg_rdata <= '0;
			res <= '{default: '0};
			refc <= '{default: '0};
		end else if (ce) begin
			state <= next_state;
			cfg <= next_cfg;
			pos <= next_pos;
			acc <= next_acc;
			err_single <= next_err_single;
			err_multi <= next_err_multi;
			done <= next_done;
			reg_rdata <= next_rdata;
			res <= next_res;
			refc <= next_refc;
		end
	end
endmodule : ecr_top
`default_nettype wire

// File: rtl/ecr_map.svh
`ifndef ECR_MAP_SVH
`define ECR_MAP_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define ECR_RES_BASE 8'h00
`define ECR_CTRL 8'h40
`define ECR_STAT 8'h44
`define ECR_ERR 8'h48
`define ECR_REF_BASE 8'h80
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ECR_CTRL_START 0
`define ECR_CTRL_OP_READ 1
`define ECR_CTRL_LAYOUT_256 2
`define ECR_CTRL_PAGE_LSB 3
`define ECR_CTRL_RESET 4'h0
// ----------------------------------------------------------------
// status fields and result word layout
// ----------------------------------------------------------------
`define ECR_STAT_BUSY 0
`define ECR_STAT_DONE 1
`define ECR_NP_LSB 12
`define ECR_MASK_512 12'hfff
`define ECR_MASK_256 12'h7ff
// ----------------------------------------------------------------
// page sizes in bytes and the last byte index of a sector
// ----------------------------------------------------------------
`define ECR_PAGE_512 13'h0200
`define ECR_PAGE_2048 13'h0800
`define ECR_PAGE_4096 13'h1000
`define ECR_SECT_LAST_512 9'h1ff
`define ECR_SECT_LAST_256 9'h0ff
`endif

// File: rtl/ecr_pkg.sv
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package ecr_pkg;
	// engine state
	typedef enum logic {st_idle, st_run} ecr_state_e;
	// page configuration latched by any control write while idle
	typedef struct packed {
		logic op_read; // page read when set, page write when clear
		logic layout_256; // one code per 256 bytes when set
		logic [1:0] page_sel; // 0: 512, 1: 2048, else 4096 bytes
	} ecr_cfg_s;
endpackage : ecr_pkg

// File: rtl/ecr_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// small byte fifo between the page stream and the code engine
// ----------------------------------------------------------------
module ecr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [AW-1:0] wptr, next_wptr; // write slot
	logic [AW-1:0] rptr, next_rptr; // oldest slot
	logic [CW-1:0] count, next_count; // words held
	logic next_in_ready;
	logic push;
	logic pop;

	assign out_valid = (count != '0);
	assign out_data = mem[rptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// next state; ready is registered so the full flag is honest a cycle early
	always_comb begin
		next_mem = mem;
		next_wptr = wptr;
		next_rptr = rptr;
		next_count = count;
		if (push) begin
			next_mem[wptr] = in_data;
			next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
		end
		if (pop) begin
			next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		next_in_ready = (next_count < CW'(DEPTH));
	end

	// registers; reset acts regardless of the clock enable, otherwise a low clock enable freezes everything
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
		end else if (ce) begin
			mem <= next_mem;
			wptr <= next_wptr;
			rptr <= next_rptr;
			count <= next_count;
			in_ready <= next_in_ready;
		end
	end
endmodule : ecr_fifo
`default_nettype wire

// File: verif/ecr_src.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// page byte source standing in for the flash data path
// ----
module ecr_src (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic slow,
	input wire logic [12:0] len,
	input wire logic [2:0][15:0] fl,
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	logic act; // page in progress
	logic [12:0] i; // index of the byte on offer
	logic [7:0] last; // last byte taken
	// a flip entry is {enable, byte index, bit}
	function automatic logic [7:0] pg(input logic [12:0] a);
		pg = 8'h0;
		for (int k = 0; k < 3; k++) if (fl[k][15] && fl[k][14:3] == a[11:0]) pg[fl[k][2:0]] = 1'b1;
	endfunction : pg
	// when nothing is offered the lines show garbage, not the old byte
	assign byte_data = byte_valid ? pg(i) : ~last;
	initial begin
		act = 1'b0;
		byte_valid = 1'b0;
		i = 13'h0;
		last = 8'h0;
	end
	// an offer is held until taken; slow mode gaps each byte
	always @(posedge clk_sys) begin
		if (go) begin
			act <= 1'b1;
			i <= 13'h0;
			byte_valid <= 1'b0;
		end else if (byte_valid && byte_ready) begin
			last <= byte_data;
			i <= i + 13'h1;
			byte_valid <= !slow && (i + 13'h1 != len);
			act <= (i + 13'h1 != len);
		end else if (act && !byte_valid) begin
			byte_valid <= 1'b1;
		end
	end
endmodule : ecr_src
`default_nettype wire

// File: verif/ecr_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// port checker, register side
// ----
module ecr_chk #(
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic byte_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_idle_rdata_zero: assert property (ce && !reg_rd |=> reg_rdata == 32'h0) else $error("stray read data");
	a_reset_clears: assert property (disable iff (1'b0) !nrst && ce |=> reg_rdata == 32'h0 && byte_ready)
		else $error("reset state wrong");
	a_result_top_zero: assert property (ce && reg_rd && reg_addr < 8'h40 |=> reg_rdata[31:24] == 8'h0)
		else $error("result top bits set");
	a_start_reads_zero: assert property (ce && reg_rd && reg_addr == 8'h40 |=> !reg_rdata[0])
		else $error("start bit read back");
	a_status_top_zero: assert property (ce && reg_rd && reg_addr == 8'h44 |=> reg_rdata[31:2] == 30'h0)
		else $error("status top bits set");
	a_busy_not_done: assert property (ce && reg_rd && reg_addr == 8'h44 |=> !(reg_rdata[0] && reg_rdata[1]))
		else $error("busy and done together");
	a_unmapped_zero: assert property (ce && reg_rd && reg_addr == 8'h4c |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_unaligned_zero: assert property (ce && reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
		else $error("unaligned read not zero");
endmodule : ecr_chk
bind ecr_top ecr_chk #(.DEPTH(DEPTH)) ecr_chk_inst (.clk_sys, .nrst, .ce, .reg_addr, .reg_rd, .reg_rdata,
	.byte_ready);
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, go = 0, slow = 0, ce = 1;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic byte_valid, byte_ready;
	logic [7:0] byte_data;
	logic [12:0] len = 13'h0;
	logic [2:0][15:0] fl = '0; // flipped bits of the page
	int num_errors = 0, n_tests = 0;
	always #2 clk_sys = ~clk_sys;
	ecr_top ecr_top_inst (.clk_sys, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.byte_valid, .byte_data, .byte_ready);
	ecr_src ecr_src_inst (.clk_sys, .go, .slow, .len, .fl, .byte_ready, .byte_valid, .byte_data);
	// ----
	// bus and check helpers
	// ----
	task automatic report_and_stop;
		if (num_errors == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rdchk
	// start a page and poll status until done, bounded
	task automatic run(input logic [31:0] c, input logic [12:0] n);
		wr(8'h40, c);
		len <= n;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		for (int k = 0; k < 9000; k++) begin
			@(posedge clk_sys);
			reg_addr <= 8'h44;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1 if (reg_rdata[1] === 1'b1) return;
		end
		$display("wrong value at %0t: page never finished", $time);
		num_errors++;
		report_and_stop;
	endtask : run
	// ----
	// scenarios
	// ----
	task automatic t_wr4096;
		slow <= 1'b1; // stalling source feeds fifo slowly
		fl <= {16'h0, 16'hf000, 16'hefff};
		run(32'h11, 13'h1000);
		rdchk(8'h14, 32'h0);
		rdchk(8'h18, 32'h00000fff);
		rdchk(8'h1c, 32'h00fff000);
	endtask : t_wr4096
	task automatic t_rd512;
		slow <= 1'b0;
		fl <= {32'h0, 16'h896d};
		run(32'h03, 13'h200);
		rdchk(8'h00, 32'h0096d96d);
		rdchk(8'h48, 32'h1);
	endtask : t_rd512
	task automatic t_rd256;
		fl <= {16'h9c21, 16'h9800, 16'h8d5b}; // one flip in sector 1, two in sector 3
		run(32'h0f, 13'h800);
		rdchk(8'h04, 32'h0055b55b);
		rdchk(8'h48, 32'h00080002);
	endtask : t_rd256
	task automatic t_ro;
		wr(8'h04, 32'hffffffff);
		wr(8'h48, 32'h0);
		rdchk(8'h04, 32'h0055b55b);
		rdchk(8'h48, 32'h00080002);
		rdchk(8'h40, 32'h0e);
		rdchk(8'h44, 32'h2);
		rdchk(8'h4c, 32'h0);
		rdchk(8'h41, 32'h0);
	endtask : t_ro
	// idle engine never drains, so the fifo takes 8 and refuses
	task automatic t_full;
		int n;
		n = 0;
		fl <= '0;
		len <= 13'h10;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (30) begin
			@(posedge clk_sys);
			// look after the edge has settled, at the values the next edge takes
			#1 if (byte_valid && byte_ready) n++;
		end
		chk(32'(n), 32'h8);
		chk({31'h0, byte_ready}, 32'h0);
	endtask : t_full
	// a low clock enable must keep a read from being taken at all
	task automatic t_ce;
		@(posedge clk_sys);
		ce <= 1'b0;
		reg_addr <= 8'h44;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, 32'h0);
		@(posedge clk_sys);
		ce <= 1'b1;
		rdchk(8'h44, 32'h2);
	endtask : t_ce
	initial begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		t_wr4096;
		t_rd512;
		t_rd256;
		t_ro;
		t_full;
		t_ce;
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
